// *** hw/ahb_retry_hold_and_test_slave.sv ***
// Purpose: pseudo-ahb to ahb hold/replay stage plus test slave state machine
// Assumes: all inputs are synchronous to ref_clk (core and bus share the clock)
// Notes: ahb outputs are registered, one cycle behind the live upstream transfer
// Operation
// - split, retry or lost grant keeps the transfer and stalls upstream ready
// - holding registers capture the upstream transfer on every ready cycle, the data-phase copy on a split/retry
// - outputs muxed by next-state hold_select_d, set and cleared by pulses
// - hold_set on split/retry in data phase or grant lost on active transfer
// - hold_clear when holding, bus owned again, split/retry response over and replayed first beat gone out
// - replayed burst with unknown remaining beats is driven as incr
// - a wholly untransferred incr4 burst keeps its incr4 type
// - core granted only in master mode, withheld in all test states
// - first slave access enters reset state for eight cycles, core reset, ahb waited
// - single end-of-reset state releases the wait for the first access
// - one waited turnaround cycle between a write and a following read
// - three pause states keep grant withheld, accesses go straight to access state
// - test operation leaves through an exit state before master mode
// - state changes on rising edge, same access type keeps the state
// - falling edge releases reset, makes grant, delays grant, samples core data
// - only rising-edge flops, falling edge via an inverted clock
// - latch holds upper core transfer-type bit while the clock is high
// - wait, error and last drivers enabled by a clock-ored enable
`timescale 1ns/1ps
`default_nettype none
module ahb_retry_hold_and_test_slave #(
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // upstream pseudo-ahb
  input wire logic [1:0] up_trans,
  input wire logic [ADDR_W-1:0] up_addr,
  input wire logic up_write,
  input wire logic [2:0] up_size,
  input wire logic [2:0] up_burst,
  output logic upstream_ready,
  // ahb master
  input wire logic master_bus_grant,
  input wire logic m_ready,
  input wire logic [1:0] m_resp,
  output logic [1:0] m_trans,
  output logic [ADDR_W-1:0] m_addr,
  output logic m_write,
  output logic [2:0] m_size,
  output logic [2:0] master_burst_type,
  // ahb test slave port
  input wire logic s_sel,
  input wire logic [1:0] s_trans,
  input wire logic s_write,
  input wire logic s_ready_in,
  input wire logic [DATA_W-1:0] s_wdata,
  output logic slave_ready_out,
  output logic [DATA_W-1:0] slave_read_data,
  // core side
  input wire logic [1:0] core_transfer_type,
  input wire logic resp_drive_req,
  input wire logic [DATA_W-1:0] core_data_in,
  output logic core_bus_grant,
  output logic core_reset_n,
  output logic core_write_out,
  output logic core_write_oe,
  output logic [DATA_W-1:0] core_data_out,
  output logic core_data_oe,
  output logic core_tran_hi,
  output logic response_tristate_enable_n
);
  // ---------------- hold / replay ----------------
  logic hold_select_q, hold_select_d, hold_set_pulse, hold_clear_pulse;
  logic dphase_q, replay_first_q;
  logic [1:0] h_trans_q;
  logic [ADDR_W-1:0] h_addr_q;
  logic h_write_q;
  logic [2:0] h_size_q, h_burst_q;
  logic up_ready_q;
  logic [1:0] m_trans_q;
  logic [ADDR_W-1:0] m_addr_q;
  logic m_write_q;
  logic [2:0] m_size_q, m_burst_q;
  // copy of the transfer now in its data phase, the one a retry or split hits
  logic [1:0] dp_trans_q;
  logic [ADDR_W-1:0] dp_addr_q;
  logic dp_write_q;
  logic [2:0] dp_size_q, dp_burst_q;

  wire resp_hold = (m_resp == bridge_pkg::RS_SPLIT) || (m_resp == bridge_pkg::RS_RETRY);
  wire m_active = (m_trans_q == bridge_pkg::TR_NSEQ) || (m_trans_q == bridge_pkg::TR_SEQ);
  wire up_valid = up_ready_q && !hold_select_q;
  wire up_active = up_valid && up_trans[1];
  // grant is judged for the transfer about to leave, not the one already out
  wire grant_lost = up_active && !master_bus_grant && m_ready;
  wire resp_set = dphase_q && resp_hold;
  assign hold_set_pulse = resp_set || grant_lost;
  // stay holding until the replayed first beat has actually gone out
  assign hold_clear_pulse = hold_select_q && master_bus_grant && !resp_hold &&
                            !replay_first_q;
  // set wins: a fresh split in the clearing cycle must not be lost
  assign hold_select_d = hold_set_pulse || (hold_select_q && !hold_clear_pulse);
  // whole incr4 untouched keeps its type, otherwise remaining count unknown
  wire keep_burst = (h_trans_q == bridge_pkg::TR_NSEQ);
  wire [2:0] replay_burst = keep_burst ? h_burst_q : bridge_pkg::BU_INCR;
  wire [1:0] replay_trans = (replay_first_q && h_trans_q != bridge_pkg::TR_IDLE) ?
                            bridge_pkg::TR_NSEQ : h_trans_q;
  // idle in the cancel cycle and while a pending replay has no grant
  wire force_idle = hold_set_pulse || (hold_select_d && !master_bus_grant);
  wire [1:0] sel_trans = hold_select_d ? replay_trans : up_trans;
  wire [1:0] mux_trans = force_idle ? bridge_pkg::TR_IDLE : sel_trans;
  wire [ADDR_W-1:0] mux_addr = hold_select_d ? h_addr_q : up_addr;
  wire mux_write = hold_select_d ? h_write_q : up_write;
  wire [2:0] mux_size = hold_select_d ? h_size_q : up_size;
  wire [2:0] mux_burst = hold_select_d ? replay_burst : up_burst;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hold_select_q <= 1'b0;
      up_ready_q <= 1'b0;
      dphase_q <= 1'b0;
      replay_first_q <= 1'b0;
    end else begin
      hold_select_q <= hold_select_d;
      up_ready_q <= m_ready && !hold_select_d;
      if (m_ready) dphase_q <= m_active;
      else if (hold_set_pulse) dphase_q <= 1'b0;
      if (hold_set_pulse) replay_first_q <= 1'b1;
      else if (hold_select_q && master_bus_grant && m_ready) replay_first_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      h_trans_q <= bridge_pkg::TR_IDLE;
      h_addr_q <= '0;
      h_write_q <= 1'b0;
      h_size_q <= 3'h0;
      h_burst_q <= 3'h0;
    end else if (resp_set) begin
      h_trans_q <= dp_trans_q;
      h_addr_q <= dp_addr_q;
      h_write_q <= dp_write_q;
      h_size_q <= dp_size_q;
      h_burst_q <= dp_burst_q;
    end else if (up_valid) begin
      h_trans_q <= up_trans;
      h_addr_q <= up_addr;
      h_write_q <= up_write;
      h_size_q <= up_size;
      h_burst_q <= up_burst;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      m_trans_q <= bridge_pkg::TR_IDLE;
      m_addr_q <= '0;
      m_write_q <= 1'b0;
      m_size_q <= 3'h0;
      m_burst_q <= 3'h0;
    end else if (m_ready || hold_set_pulse) begin
      m_trans_q <= mux_trans;
      m_addr_q <= mux_addr;
      m_write_q <= mux_write;
      m_size_q <= mux_size;
      m_burst_q <= mux_burst;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      dp_trans_q <= bridge_pkg::TR_IDLE;
      dp_addr_q <= '0;
      dp_write_q <= 1'b0;
      dp_size_q <= 3'h0;
      dp_burst_q <= 3'h0;
    end else if (m_ready) begin
      dp_trans_q <= m_trans_q;
      dp_addr_q <= m_addr_q;
      dp_write_q <= m_write_q;
      dp_size_q <= m_size_q;
      dp_burst_q <= m_burst_q;
    end
  end

  assign upstream_ready = up_ready_q;
  assign m_trans = m_trans_q;
  assign m_addr = m_addr_q;
  assign m_write = m_write_q;
  assign m_size = m_size_q;
  assign master_burst_type = m_burst_q;

  // ---------------- core transfer-type latch and response enable ----------------
  logic tran_hi_lat, tran_hi_q, resp_en_n_q;
  // bus floats while the clock is high, so only follow it in the low phase
  always_latch begin
    if (!ref_clk) tran_hi_lat <= core_transfer_type[1];
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tran_hi_q <= 1'b0;
      resp_en_n_q <= 1'b1;
    end else begin
      tran_hi_q <= tran_hi_lat;
      resp_en_n_q <= !resp_drive_req;
    end
  end
  assign core_tran_hi = tran_hi_q;
  // clock or: drivers only open in the low phase; needs a clock-tree stop point
  assign response_tristate_enable_n = ref_clk | resp_en_n_q;

  // ---------------- test slave state machine ----------------
  bridge_pkg::test_state_t st_q, st_d;
  logic [3:0] rst_cnt_q;
  logic s_ready_q;
  wire acc = s_sel && s_ready_in && s_trans[1];
  wire acc_wr = acc && s_write;
  wire acc_rd = acc && !s_write;
  wire cnt_done = (rst_cnt_q == 4'(bridge_pkg::RESET_CYCLES - 1));

  always_comb begin
    st_d = st_q;
    case (st_q)
      bridge_pkg::st_master_mode: if (acc) st_d = bridge_pkg::st_test_reset;
      bridge_pkg::st_test_reset: if (cnt_done) st_d = bridge_pkg::st_last_reset;
      bridge_pkg::st_last_reset: st_d = bridge_pkg::st_test_write;
      bridge_pkg::st_test_write: begin
        if (acc_rd) st_d = bridge_pkg::st_turnaround;
        else if (!acc_wr) st_d = bridge_pkg::st_test_pause_state;
      end
      bridge_pkg::st_turnaround: st_d = bridge_pkg::st_test_read;
      bridge_pkg::st_test_read: begin
        if (acc_wr) st_d = bridge_pkg::st_test_write;
        else if (!acc_rd) st_d = bridge_pkg::st_test_pause_state;
      end
      bridge_pkg::st_test_pause_state: begin
        if (acc_wr) st_d = bridge_pkg::st_test_write;
        else if (acc_rd) st_d = bridge_pkg::st_test_read;
        else st_d = bridge_pkg::st_pause2;
      end
      bridge_pkg::st_pause2: begin
        if (acc_wr) st_d = bridge_pkg::st_test_write;
        else if (acc_rd) st_d = bridge_pkg::st_test_read;
        else st_d = bridge_pkg::st_pause3;
      end
      bridge_pkg::st_pause3: begin
        if (acc_wr) st_d = bridge_pkg::st_test_write;
        else if (acc_rd) st_d = bridge_pkg::st_test_read;
        else st_d = bridge_pkg::st_exit_test;
      end
      bridge_pkg::st_exit_test: st_d = bridge_pkg::st_master_mode;
      default: st_d = bridge_pkg::st_master_mode;
    endcase
  end

  wire wait_d = (st_d == bridge_pkg::st_test_reset) || (st_d == bridge_pkg::st_turnaround);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q <= bridge_pkg::st_master_mode;
      rst_cnt_q <= 4'h0;
      s_ready_q <= 1'b1;
    end else begin
      st_q <= st_d;
      rst_cnt_q <= (st_q == bridge_pkg::st_test_reset) ? rst_cnt_q + 4'h1 : 4'h0;
      s_ready_q <= !wait_d;
    end
  end
  assign slave_ready_out = s_ready_q;

  // ---------------- falling-edge side ----------------
  logic inverted_clock;
  logic core_grant_falling, delayed_core_grant, core_rst_n_q;
  logic [DATA_W-1:0] rdata_q;
  logic wr_drv_q, wr_val_q;
  logic [DATA_W-1:0] wdata_q;
  assign inverted_clock = ~ref_clk;
  wire in_master = (st_q == bridge_pkg::st_master_mode);
  wire in_write = (st_q == bridge_pkg::st_test_write);
  always_ff @(posedge inverted_clock) begin
    if (srst) begin
      core_rst_n_q <= 1'b0;
      core_grant_falling <= 1'b0;
      delayed_core_grant <= 1'b0;
      rdata_q <= '0;
    end else begin
      core_rst_n_q <= (st_q != bridge_pkg::st_test_reset);
      core_grant_falling <= in_master;
      delayed_core_grant <= core_grant_falling;
      rdata_q <= core_data_in;
    end
  end
  // drive the write line only once the core has let go of the bus
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_drv_q <= 1'b0;
      wr_val_q <= 1'b0;
      wdata_q <= '0;
    end else begin
      wr_drv_q <= !delayed_core_grant && !core_grant_falling && !in_master;
      wr_val_q <= in_write;
      wdata_q <= s_wdata;
    end
  end
  assign core_bus_grant = core_grant_falling;
  assign core_reset_n = core_rst_n_q;
  assign slave_read_data = rdata_q;
  assign core_write_oe = wr_drv_q;
  assign core_write_out = wr_val_q;
  assign core_data_oe = wr_drv_q && wr_val_q;
  assign core_data_out = wdata_q;

  // ---------------- assertions ----------------
  sequence s_hold_start;
    hold_set_pulse;
  endsequence
  sequence s_stalled;
    !upstream_ready;
  endsequence
  a_hold_stall: assert property (@(posedge ref_clk) disable iff (srst)
    s_hold_start |=> s_stalled) else $error("upstream not stalled on hold");
  a_hold_capture: assert property (@(posedge ref_clk) disable iff (srst)
    up_valid && !resp_set |=> h_addr_q == $past(up_addr)) else $error("hold regs missed capture");
  a_hold_flag: assert property (@(posedge ref_clk) disable iff (srst)
    hold_set_pulse |=> hold_select_q) else $error("hold_select not set");
  a_clear_cond: assert property (@(posedge ref_clk) disable iff (srst)
    hold_select_q && !hold_set_pulse && master_bus_grant && !resp_hold && !replay_first_q
    |=> !hold_select_q) else $error("hold not released");
  a_replay_nseq: assert property (@(posedge ref_clk) disable iff (srst)
    hold_select_q && replay_first_q && master_bus_grant && m_ready && !hold_set_pulse &&
    h_trans_q != bridge_pkg::TR_IDLE |=> m_trans == bridge_pkg::TR_NSEQ)
    else $error("replay first beat not nonseq");
  a_ungranted_idle: assert property (@(posedge ref_clk) disable iff (srst)
    hold_select_d && !master_bus_grant && (m_ready || hold_set_pulse)
    |=> m_trans == bridge_pkg::TR_IDLE) else $error("ungranted replay driven");
  a_core_held: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == bridge_pkg::st_test_reset |-> !core_reset_n) else $error("core not held in reset");
  a_replay_incr: assert property (@(posedge ref_clk) disable iff (srst)
    hold_select_d && (m_ready || hold_set_pulse) && h_trans_q == bridge_pkg::TR_SEQ
    |=> master_burst_type == bridge_pkg::BU_INCR) else $error("replay burst not incr");
  a_grant_mode: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == bridge_pkg::st_test_write |-> !core_bus_grant) else $error("core granted in test");
  sequence s_reset_run;
    (st_q == bridge_pkg::st_test_reset)[*8];
  endsequence
  a_reset_len: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == bridge_pkg::st_master_mode && acc |=> s_reset_run ##1 st_q == bridge_pkg::st_last_reset)
    else $error("reset state length wrong");
  a_turn_wait: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == bridge_pkg::st_test_write && acc_rd |=> !slave_ready_out ##1 st_q == bridge_pkg::st_test_read)
    else $error("turnaround missing");
  a_exit_path: assert property (@(posedge ref_clk) disable iff (srst)
    st_q == bridge_pkg::st_exit_test |=> st_q == bridge_pkg::st_master_mode)
    else $error("exit not to master mode");
endmodule // ahb_retry_hold_and_test_slave
`default_nettype wire

// *** hw/bridge_pkg.sv ***
// Purpose: shared constants for the hold/replay bridge and test slave
// Assumes: ahb encodings for trans, burst and resp
// Notes: none
package bridge_pkg;
  localparam logic [1:0] TR_IDLE = 2'h0;
  localparam logic [1:0] TR_BUSY = 2'h1;
  localparam logic [1:0] TR_NSEQ = 2'h2;
  localparam logic [1:0] TR_SEQ = 2'h3;
  localparam logic [2:0] BU_INCR = 3'h1;
  localparam logic [2:0] BU_INCR4 = 3'h3;
  localparam logic [1:0] RS_OKAY = 2'h0;
  localparam logic [1:0] RS_RETRY = 2'h2;
  localparam logic [1:0] RS_SPLIT = 2'h3;
  localparam int RESET_CYCLES = 8;
  typedef enum logic [3:0] {
    st_master_mode, st_test_reset, st_last_reset, st_test_write, st_turnaround,
    st_test_read, st_test_pause_state, st_pause2, st_pause3, st_exit_test
  } test_state_t;
endpackage

// *** verif/ahb_retry_hold_and_test_slave_tb.sv ***
// Purpose: self-checking bench for hold/replay stage and test slave
// Assumes: inputs change on the falling edge, except t_core's second values, set 1 ns after it
// Notes: waits are bounded; a run-out counts as a mismatch
`timescale 1ns/1ps
`default_nettype none
module ahb_retry_hold_and_test_slave_tb;
  logic ref_clk, srst, up_write, upstream_ready, m_ready, m_write, s_sel, s_write, s_ready_in;
  logic slave_ready_out, core_bus_grant, core_reset_n, core_write_out, core_write_oe;
  logic core_data_oe, core_tran_hi, response_tristate_enable_n, master_bus_grant;
  logic arm, grant_en, stall, resp_req;
  logic [1:0] up_trans, m_trans, m_resp, s_trans, code, tran_bits;
  logic [2:0] up_burst, m_size, master_burst_type;
  logic [31:0] up_addr, m_addr, s_wdata, slave_read_data, core_data_in, core_data_out;
  int n_errors, check_count, k;
  ahb_retry_hold_and_test_slave uut (.ref_clk(ref_clk), .srst(srst), .up_trans(up_trans),
    .up_addr(up_addr), .up_write(up_write), .up_size(3'h2), .up_burst(up_burst),
    .upstream_ready(upstream_ready), .master_bus_grant(master_bus_grant), .m_ready(m_ready),
    .m_resp(m_resp), .m_trans(m_trans), .m_addr(m_addr), .m_write(m_write), .m_size(m_size),
    .master_burst_type(master_burst_type), .s_sel(s_sel), .s_trans(s_trans), .s_write(s_write),
    .s_ready_in(s_ready_in), .s_wdata(s_wdata), .slave_ready_out(slave_ready_out),
    .slave_read_data(slave_read_data), .core_transfer_type(tran_bits), .resp_drive_req(resp_req),
    .core_data_in(core_data_in), .core_bus_grant(core_bus_grant), .core_reset_n(core_reset_n),
    .core_write_out(core_write_out), .core_write_oe(core_write_oe),
    .core_data_out(core_data_out), .core_data_oe(core_data_oe), .core_tran_hi(core_tran_hi),
    .response_tristate_enable_n(response_tristate_enable_n));
  far_side_model far (.ref_clk(ref_clk), .srst(srst), .arm(arm), .code(code),
    .grant_en(grant_en), .stall(stall), .m_trans(m_trans), .master_bus_grant(master_bus_grant),
    .m_ready(m_ready), .m_resp(m_resp), .core_data_oe(core_data_oe),
    .core_data_out(core_data_out), .core_data_in(core_data_in));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic wrap_up;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic nxt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // present a transfer and return one edge after it was taken
  task automatic up_go(input logic [1:0] t, input logic [31:0] a, input logic [2:0] b);
    up_trans = t;
    up_addr = a;
    up_burst = b;
    k = 0;
    while (upstream_ready !== 1'b1 && k < 40) begin nxt(1); k++; end
    chk(k < 40, 1'b1);
    nxt(1);
  endtask
  task automatic wait_replay(input logic [31:0] a);
    k = 0;
    while (!(m_trans === bridge_pkg::TR_NSEQ && m_addr === a) && k < 30) begin nxt(1); k++; end
    chk(k < 30, 1'b1);
  endtask
  task automatic t_pass;
    up_go(bridge_pkg::TR_NSEQ, 32'h0000_1000, bridge_pkg::BU_INCR4);
    chk(m_trans, bridge_pkg::TR_NSEQ);
    chk(m_addr, 32'h0000_1000);
    chk({m_write, m_size}, 4'ha);
    up_trans = bridge_pkg::TR_BUSY;
    stall = 1'b1;
    nxt(2);
    stall = 1'b0;
    up_go(bridge_pkg::TR_SEQ, 32'h0000_1004, bridge_pkg::BU_INCR4);
    chk(m_addr, 32'h0000_1004);
    up_trans = bridge_pkg::TR_IDLE;
    nxt(3);
  endtask
  task automatic t_bad(input logic [1:0] c, input logic [31:0] a);
    code = c;
    up_go(bridge_pkg::TR_NSEQ, a, bridge_pkg::BU_INCR4);
    up_trans = bridge_pkg::TR_IDLE;
    arm = 1'b1;
    nxt(1);
    arm = 1'b0;
    k = 0;
    while (upstream_ready !== 1'b0 && k < 6) begin nxt(1); k++; end
    chk(k < 6, 1'b1);
    k = 0;
    while (m_trans !== bridge_pkg::TR_IDLE && k < 8) begin nxt(1); k++; end
    chk(k < 8, 1'b1);
    wait_replay(a);
    chk(master_burst_type, bridge_pkg::BU_INCR4);
    k = 0;
    while (upstream_ready !== 1'b1 && k < 20) begin nxt(1); k++; end
    chk(k < 20, 1'b1);
    nxt(3);
  endtask
  task automatic t_grant;
    up_go(bridge_pkg::TR_NSEQ, 32'h0000_2000, bridge_pkg::BU_INCR4);
    grant_en = 1'b0;
    up_go(bridge_pkg::TR_SEQ, 32'h0000_2004, bridge_pkg::BU_INCR4);
    up_trans = bridge_pkg::TR_IDLE;
    nxt(4);
    chk(upstream_ready, 1'b0);
    grant_en = 1'b1;
    wait_replay(32'h0000_2004);
    chk(master_burst_type, bridge_pkg::BU_INCR);
    nxt(4);
    grant_en = 1'b0;
    up_go(bridge_pkg::TR_NSEQ, 32'h0000_3000, bridge_pkg::BU_INCR4);
    up_trans = bridge_pkg::TR_IDLE;
    nxt(4);
    grant_en = 1'b1;
    wait_replay(32'h0000_3000);
    chk(master_burst_type, bridge_pkg::BU_INCR4);
    nxt(4);
  endtask
  // enable output is clock-ored, so look just after the falling edge has settled
  task automatic t_core;
    tran_bits = 2'h2;
    resp_req = 1'b1;
    nxt(2);
    #1;
    chk({core_tran_hi, response_tristate_enable_n}, 2'h2);
    tran_bits = 2'h0;
    resp_req = 1'b0;
    nxt(2);
    #1;
    chk({core_tran_hi, response_tristate_enable_n}, 2'h1);
    nxt(1);
  endtask
  // counts waited cycles from the edge after an access change
  task automatic lows(output int n);
    nxt(1);
    n = 0;
    while (slave_ready_out !== 1'b1 && n < 20) begin
      if (n == 4) chk({core_reset_n, core_bus_grant}, 2'h0);
      nxt(1);
      n++;
    end
  endtask
  task automatic t_tic;
    int n;
    s_sel = 1'b1;
    s_trans = bridge_pkg::TR_NSEQ;
    s_write = 1'b1;
    s_wdata = 32'hc0de_0001;
    lows(n);
    chk(n, bridge_pkg::RESET_CYCLES);
    nxt(2);
    chk(slave_ready_out, 1'b1);
    chk({core_write_oe, core_write_out, core_data_oe}, 3'h7);
    chk(core_data_out, 32'hc0de_0001);
    s_write = 1'b0;
    lows(n);
    chk(n, 1);
    nxt(2);
    chk(slave_read_data, far.CORE_WORD);
    s_sel = 1'b0;
    nxt(2);
    chk(core_bus_grant, 1'b0);
    s_sel = 1'b1;
    s_write = 1'b1;
    lows(n);
    chk(n, 0);
    s_sel = 1'b0;
    n = 0;
    while (core_bus_grant !== 1'b1 && n < 20) begin nxt(1); n++; end
    chk(n >= 4 && n < 20, 1'b1);
  endtask
  initial begin
    #80000;
    n_errors++;
    wrap_up;
  end
  initial begin
    {srst, grant_en} = 2'h3;
    {up_write, arm, stall, s_sel, s_write, s_ready_in} = 6'h21;
    {up_trans, code, s_trans, tran_bits} = 8'h0;
    resp_req = 1'b0;
    {up_burst, up_addr, s_wdata} = '0;
    nxt(6);
    srst <= 1'b0;
    nxt(2);
    chk({core_bus_grant, slave_ready_out, core_reset_n}, 3'h7);
    t_pass;
    t_bad(bridge_pkg::RS_RETRY, 32'h0000_1100);
    t_bad(bridge_pkg::RS_SPLIT, 32'h0000_1200);
    t_grant;
    t_core;
    t_tic;
    wrap_up;
  end
endmodule // ahb_retry_hold_and_test_slave_tb
`default_nettype wire

// *** verif/far_side_model.sv ***
// Purpose: ahb slave, arbiter and core stand-in for the hold stage
// Assumes: one clock; retry and split take two response cycles
// Notes: a bad response hits the address phase accepted while arm is high
`timescale 1ns/1ps
`default_nettype none
module far_side_model #(
  parameter logic [31:0] CORE_WORD = 32'h5a3c_96e1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bench control
  input wire logic arm,
  input wire logic [1:0] code,
  input wire logic grant_en,
  input wire logic stall,
  // ahb master side
  input wire logic [1:0] m_trans,
  output logic master_bus_grant,
  output logic m_ready,
  output logic [1:0] m_resp,
  // core side
  input wire logic core_data_oe,
  input wire logic [31:0] core_data_out,
  output logic [31:0] core_data_in
);
  logic [1:0] st_q;
  logic [1:0] st_d;
  // 1: first response cycle (waited), 2: second cycle (ready)
  assign st_d = (st_q == 2'h1) ? 2'h2 :
    (st_q == 2'h0 && arm && m_ready && m_trans[1]) ? 2'h1 : 2'h0;
  always_ff @(posedge ref_clk) begin
    if (srst) st_q <= 2'h0;
    else st_q <= st_d;
  end
  assign master_bus_grant = grant_en;
  assign m_ready = (st_q != 2'h1) && !stall;
  assign m_resp = (st_q != 2'h0) ? code : bridge_pkg::RS_OKAY;
  // core never waits; its word shows whenever the wrapper lets go
  assign core_data_in = core_data_oe ? core_data_out : CORE_WORD;
endmodule // far_side_model
`default_nettype wire
